// File: rtl/psic_input_control.sv
// input control, burst counter and data pipeline of the burst memory
//
// How it works
// [RULE_01] Captured address selects the one location used for the access.
// [RULE_02] Address, control and write data are taken on rising clock edges only.
// [RULE_03] Clock qualify high makes an edge void; only a low qualify counts.
// [RULE_04] Lane write selects are active low and count only with write enable.
// [RULE_05] Each lane select gates exactly its own nine-bit lane, parity included.
// [RULE_06] Write enable is sampled only on edges where clock qualify is low.
// [RULE_07] The controller drives write enable low to write; otherwise it reads.
// [RULE_08] Step/reload high on a qualified edge advances the burst counter.
// [RULE_09] Step/reload low loads the address inputs as a new access start.
// [RULE_10] Controller reloads, not steps, on the first access after deselect.
// [RULE_11] First select term, active low, joins the other two to select.
// [RULE_12] Third select term, active low, is one of the three select terms.
// [RULE_13] Clock qualify high freezes every state; it never deselects. The strap capture after reset release is not gated by it.
// [RULE_14] Read data are those of the address captured one edge earlier.
// [RULE_15] Data pins float in write data phase, after deselect and deselected.
// [RULE_16] Strap high gives interleaved order, low linear; held constant.
// [RULE_17] Selected only with first and third low and second high together.
// [RULE_18] Burst steps only the two low address bits, wrapping in four.
`timescale 1ns/1ps
`default_nettype none

module psic_input_control (
	// clock and reset
	input  wire logic                          clk,
	input  wire logic                          rst_b,
	// synchronous control inputs
	input  wire psic_pkg::psic_ctrl_t          ctrl,
	input  wire logic [psic_pkg::UPPER_W-1:0]  addrUpper,
	input  wire logic                          burstAddrBitOne,
	input  wire logic                          burstAddrBitZero,
	input  wire logic                          outputEnableN,
	input  wire logic                          burstOrderStrap,
	// data pins, split into input, output and enable
	input  wire logic [psic_pkg::DATA_W-1:0]   dataIn,
	output logic      [psic_pkg::DATA_W-1:0]   dataOut,
	output logic      [psic_pkg::DATA_W-1:0]   dataOe,
	// pending access, for observation
	output logic                               accessValid,
	output logic                               accessWrite,
	output logic      [psic_pkg::ADDR_W-1:0]   accessAddr,
	output logic      [psic_pkg::LANES-1:0]    accessLanes
);
	import psic_pkg::*;

	// ****************************************************************
	// input decode
	// ****************************************************************
	logic                qualified;
	logic                selectNow;
	logic [LANES-1:0]    laneSelect;
	logic [ADDR_W-1:0]   loadAddr;
	logic                loadNow;
	logic                stepNow;

	assign qualified  = ~ctrl.clockQualifyN;                      // see [RULE_03]
	assign selectNow  = ~ctrl.selectTermFirstN & ctrl.selectTermSecond
		& ~ctrl.selectTermThirdN;                                  // see [RULE_17]
	assign laneSelect = ~{ctrl.lane3WriteSelectN, ctrl.lane2WriteSelectN,
		ctrl.lane1WriteSelectN, ctrl.lane0WriteSelectN};           // see [RULE_04]
	assign loadAddr   = {addrUpper, burstAddrBitOne, burstAddrBitZero};
	assign loadNow    = qualified & ~ctrl.burstStepOrReload;       // see [RULE_09]
	assign stepNow    = qualified & ctrl.burstStepOrReload;        // see [RULE_08]

	// ****************************************************************
	// burst order strap, caught once after reset release
	// ****************************************************************
	logic modeInterleaved;
	logic strapTaken;
	logic next_modeInterleaved;
	logic next_strapTaken;

	always_comb begin
		next_strapTaken      = 1'h1;
		next_modeInterleaved = strapTaken ? modeInterleaved : burstOrderStrap; // see [RULE_16]
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			strapTaken      <= 1'h0;
			modeInterleaved <= STRAP_RST;
		end else begin
			strapTaken      <= next_strapTaken;
			modeInterleaved <= next_modeInterleaved;
		end
	end

	// ****************************************************************
	// burst counter and access decision
	// ****************************************************************
	logic [UPPER_W-1:0]  burstUpper;
	logic [BURST_W-1:0]  burstStart;
	logic [BURST_W-1:0]  burstCount;
	logic                burstSelected;
	logic                burstWrite;
	logic [UPPER_W-1:0]  next_burstUpper;
	logic [BURST_W-1:0]  next_burstStart;
	logic [BURST_W-1:0]  next_burstCount;
	logic                next_burstSelected;
	logic                next_burstWrite;
	logic [BURST_W-1:0]  stepCount;
	logic [BURST_W-1:0]  stepLsb;
	psic_stage_t         pend;
	psic_stage_t         next_pend;

	assign stepCount = burstCount + BURST_ONE;                     // see [RULE_18]
	assign stepLsb   = modeInterleaved ? (burstStart ^ stepCount)
		: (burstStart + stepCount);

	always_comb begin
		next_burstUpper    = burstUpper;
		next_burstStart    = burstStart;
		next_burstCount    = burstCount;
		next_burstSelected = burstSelected;
		next_burstWrite    = burstWrite;
		next_pend          = pend;                                 // see [RULE_13]
		if (loadNow) begin
			next_burstUpper    = addrUpper;
			next_burstStart    = {burstAddrBitOne, burstAddrBitZero};
			next_burstCount    = BURST_ZERO;
			next_burstSelected = selectNow;                        // see [RULE_11]
			next_burstWrite    = ~ctrl.writeEnableN;               // see [RULE_06]
			next_pend.valid    = selectNow;                        // see [RULE_12]
			next_pend.write    = ~ctrl.writeEnableN;
			next_pend.addr     = loadAddr;                         // see [RULE_01]
			next_pend.lanes    = ctrl.writeEnableN ? LANES_NONE : laneSelect;
		end else if (stepNow) begin
			next_burstCount    = stepCount;
			next_pend.valid    = burstSelected;
			next_pend.write    = burstWrite;
			next_pend.addr     = {burstUpper, stepLsb};            // see [RULE_18]
			next_pend.lanes    = burstWrite ? laneSelect : LANES_NONE;
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			burstUpper    <= UPPER_RST;
			burstStart    <= BURST_ZERO;
			burstCount    <= BURST_ZERO;
			burstSelected <= 1'h0;
			burstWrite    <= 1'h0;
			pend          <= STAGE_RST;
		end else begin
			burstUpper    <= next_burstUpper;
			burstStart    <= next_burstStart;
			burstCount    <= next_burstCount;
			burstSelected <= next_burstSelected;
			burstWrite    <= next_burstWrite;
			pend          <= next_pend;
		end
	end

	// ****************************************************************
	// storage and data phase
	// ****************************************************************
	logic [LANES-1:0]   wrLanes;
	logic [DATA_W-1:0]  rdData;
	logic [DATA_W-1:0]  next_dataOut;
	logic [DATA_W-1:0]  next_dataOe;
	logic               readPhase;

	assign readPhase = pend.valid & ~pend.write;
	assign wrLanes   = (qualified & pend.valid & pend.write) ? pend.lanes
		: LANES_NONE;                                              // see [RULE_05]

	psic_storage #(
		.ADDR_W (ADDR_W),
		.LANES  (LANES),
		.LANE_W (LANE_W)
	) u_storage (
		.clk     (clk),
		.wrLanes (wrLanes),
		.wrAddr  (pend.addr),
		.wrData  (dataIn),                                         // see [RULE_02]
		.rdAddr  (pend.addr),
		.rdData  (rdData)
	);

	always_comb begin
		next_dataOut = dataOut;
		next_dataOe  = dataOe;
		if (qualified) begin
			if (readPhase) begin
				next_dataOut = rdData;                             // see [RULE_14]
				next_dataOe  = {DATA_W{~outputEnableN}};
			end else begin
				next_dataOe  = DATA_RST;                           // see [RULE_15]
			end
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			dataOut <= DATA_RST;
			dataOe  <= DATA_RST;
		end else begin
			dataOut <= next_dataOut;
			dataOe  <= next_dataOe;
		end
	end

	// ****************************************************************
	// observation outputs, straight from the pending stage
	// ****************************************************************
	assign accessValid = pend.valid;
	assign accessWrite = pend.write;
	assign accessAddr  = pend.addr;
	assign accessLanes = pend.lanes;

	// ****************************************************************
	// checks
	// ****************************************************************
	property p_load_addr;
		@(posedge clk) disable iff (!rst_b)
		loadNow |=> (accessAddr == $past(loadAddr));
	endproperty
	a_load_addr: assert property (p_load_addr) // see [RULE_01]
		else $error("loaded address not captured");

	property p_write_data_edge;
		@(posedge clk) disable iff (!rst_b)
		(qualified && pend.valid && pend.write) |-> (wrLanes == pend.lanes);
	endproperty
	a_write_data_edge: assert property (p_write_data_edge) // see [RULE_02]
		else $error("qualified write did not strobe its lanes");

	property p_freeze_stage;
		@(posedge clk) disable iff (!rst_b)
		ctrl.clockQualifyN |=> ($stable(accessAddr) && $stable(accessValid)
			&& $stable(burstCount) && $stable(accessLanes));
	endproperty
	a_freeze_stage: assert property (p_freeze_stage) // see [RULE_03]
		else $error("state moved on an unqualified edge");

	property p_lanes_need_write;
		@(posedge clk) disable iff (!rst_b)
		(loadNow && ctrl.writeEnableN) |=> (accessLanes == LANES_NONE);
	endproperty
	a_lanes_need_write: assert property (p_lanes_need_write) // see [RULE_04]
		else $error("lane selects active without write enable");

	property p_lane_gate;
		@(posedge clk) disable iff (!rst_b)
		(wrLanes != LANES_NONE) |-> ((wrLanes & ~pend.lanes) == LANES_NONE);
	endproperty
	a_lane_gate: assert property (p_lane_gate) // see [RULE_05]
		else $error("lane written without its select");

	property p_write_sample;
		@(posedge clk) disable iff (!rst_b)
		loadNow |=> (accessWrite == !$past(ctrl.writeEnableN));
	endproperty
	a_write_sample: assert property (p_write_sample) // see [RULE_06]
		else $error("write enable not sampled on load");

	property p_step_count;
		@(posedge clk) disable iff (!rst_b)
		stepNow |=> (burstCount == $past(stepCount));
	endproperty
	a_step_count: assert property (p_step_count) // see [RULE_08]
		else $error("burst counter did not advance");

	property p_load_count;
		@(posedge clk) disable iff (!rst_b)
		loadNow |=> (burstCount == BURST_ZERO);
	endproperty
	a_load_count: assert property (p_load_count) // see [RULE_09]
		else $error("burst counter not cleared on load");

	property p_select_terms;
		@(posedge clk) disable iff (!rst_b)
		loadNow |=> (accessValid == $past(selectNow));
	endproperty
	a_select_terms: assert property (p_select_terms) // see [RULE_11]
		else $error("selection does not follow the select terms");

	property p_third_term;
		@(posedge clk) disable iff (!rst_b)
		(loadNow && ctrl.selectTermThirdN) |=> !accessValid;
	endproperty
	a_third_term: assert property (p_third_term) // see [RULE_12]
		else $error("selected with third select term high");

	property p_freeze_data;
		@(posedge clk) disable iff (!rst_b)
		ctrl.clockQualifyN |=> ($stable(dataOut) && $stable(dataOe));
	endproperty
	a_freeze_data: assert property (p_freeze_data) // see [RULE_13]
		else $error("data pins changed on an unqualified edge");

	property p_read_data;
		@(posedge clk) disable iff (!rst_b)
		(qualified && readPhase) |=> (dataOut == $past(rdData));
	endproperty
	a_read_data: assert property (p_read_data) // see [RULE_14]
		else $error("read data not presented one edge after address");

	property p_float;
		@(posedge clk) disable iff (!rst_b)
		(qualified && !readPhase) |=> (dataOe == DATA_RST);
	endproperty
	a_float: assert property (p_float) // see [RULE_15]
		else $error("data pins driven outside a read data phase");

	property p_strap_hold;
		@(posedge clk) disable iff (!rst_b)
		strapTaken |=> $stable(modeInterleaved);
	endproperty
	a_strap_hold: assert property (p_strap_hold) // see [RULE_16]
		else $error("burst order changed during operation");

	property p_select_needs_second;
		@(posedge clk) disable iff (!rst_b)
		(loadNow && !ctrl.selectTermSecond) |=> !accessValid;
	endproperty
	a_select_needs_second: assert property (p_select_needs_second) // see [RULE_17]
		else $error("selected with second select term low");

	property p_upper_hold;
		@(posedge clk) disable iff (!rst_b)
		(stepNow && burstSelected) |=> (accessAddr[ADDR_W-1:BURST_W] == $past(burstUpper));
	endproperty
	a_upper_hold: assert property (p_upper_hold) // see [RULE_18]
		else $error("burst step touched the upper address bits");

endmodule

`default_nettype wire

// File: rtl/psic_pkg.sv
// shared constants and carrier types of the pipelined memory input control
package psic_pkg;

	// ****************************************************************
	// geometry
	// ****************************************************************
	localparam int ADDR_W  = 18;
	localparam int LANES   = 4;
	localparam int LANE_W  = 9;
	localparam int DATA_W  = LANES * LANE_W;
	localparam int BURST_W = 2;
	localparam int UPPER_W = ADDR_W - BURST_W;

	// ****************************************************************
	// reset values and counter constants
	// ****************************************************************
	localparam logic [BURST_W-1:0] BURST_ZERO   = 2'h0;
	localparam logic [BURST_W-1:0] BURST_ONE    = 2'h1;
	localparam logic [UPPER_W-1:0] UPPER_RST    = 16'h0000;
	localparam logic [DATA_W-1:0]  DATA_RST     = 36'h0_0000_0000;
	localparam logic [LANES-1:0]   LANES_NONE   = 4'h0;
	localparam logic               STRAP_RST    = 1'h1;

	// ****************************************************************
	// carrier types
	// ****************************************************************
	typedef struct packed {
		logic clockQualifyN;
		logic writeEnableN;
		logic burstStepOrReload;
		logic selectTermFirstN;
		logic selectTermSecond;
		logic selectTermThirdN;
		logic lane3WriteSelectN;
		logic lane2WriteSelectN;
		logic lane1WriteSelectN;
		logic lane0WriteSelectN;
	} psic_ctrl_t;

	typedef struct packed {
		logic              valid;
		logic              write;
		logic [ADDR_W-1:0] addr;
		logic [LANES-1:0]  lanes;
	} psic_stage_t;

	localparam psic_stage_t STAGE_RST = '{valid: 1'h0, write: 1'h0,
		addr: 18'h0_0000, lanes: 4'h0};

endpackage

// File: rtl/psic_storage.sv
// storage array with per-lane write gating
`timescale 1ns/1ps
`default_nettype none

module psic_storage #(
	parameter int ADDR_W = 18,
	parameter int LANES  = 4,
	parameter int LANE_W = 9
) (
	// clock
	input  wire logic                       clk,
	// write side
	input  wire logic [LANES-1:0]           wrLanes,
	input  wire logic [ADDR_W-1:0]          wrAddr,
	input  wire logic [LANES*LANE_W-1:0]    wrData,
	// read side
	input  wire logic [ADDR_W-1:0]          rdAddr,
	output logic      [LANES*LANE_W-1:0]    rdData
);

	// ****************************************************************
	// one array per lane, each lane written only by its own select
	// ****************************************************************
	genvar lane;
	generate
		for (lane = 0; lane < LANES; lane++) begin : g_lane
			logic [LANE_W-1:0] cells [0:(2**ADDR_W)-1];

			always_ff @(posedge clk) begin
				if (wrLanes[lane]) begin
					cells[wrAddr] <= wrData[lane*LANE_W +: LANE_W];
				end
			end

			assign rdData[lane*LANE_W +: LANE_W] = cells[rdAddr];
		end
	endgenerate

endmodule

`default_nettype wire

// File: verif/psic_ctrl_model.sv
// behavioural memory controller that drives the synchronous pins
`timescale 1ns/1ps
`default_nettype none

module psic_ctrl_model (
	// clock and strap choice
	input  wire logic                         clk,
	input  wire logic                         strapSel,
	// synchronous pins
	output psic_pkg::psic_ctrl_t              ctrl,
	output logic [psic_pkg::UPPER_W-1:0]      addrUpper,
	output logic                              burstAddrBitOne,
	output logic                              burstAddrBitZero,
	output logic                              outputEnableN,
	output logic                              burstOrderStrap,
	// data pins
	input  wire logic [psic_pkg::DATA_W-1:0]  dataOut,
	input  wire logic [psic_pkg::DATA_W-1:0]  dataOe,
	output logic [psic_pkg::DATA_W-1:0]       dataIn
);
	import psic_pkg::*;

	logic [DATA_W-1:0] drv;
	logic              drvEn;
	logic [DATA_W-1:0] floatVal;

	// ****************************************************************
	// pin levels
	// ****************************************************************
	// released lines show a changing pattern, never a held value
	always @(posedge clk) floatVal <= ~floatVal;
	assign dataIn = (dataOe & dataOut) | (~dataOe & (drvEn ? drv : floatVal));
	assign burstOrderStrap = strapSel;

	initial begin
		ctrl = 10'h3FF;
		addrUpper = 16'h0000;
		burstAddrBitOne = 1'h0;
		burstAddrBitZero = 1'h0;
		outputEnableN = 1'h0;
		drv = 36'h0_0000_0000;
		drvEn = 1'h0;
		floatVal = 36'h5_5555_5555;
	end

	// ****************************************************************
	// one edge of pin activity
	// ****************************************************************
	// write enable low only to write; loads after every deselect
	task automatic issue(input logic q, input logic we, input logic adv,
		input logic [2:0] sel, input logic [3:0] lnN, input logic [ADDR_W-1:0] a,
		input logic [DATA_W-1:0] d, input logic den);
		@(posedge clk);
		ctrl <= {q, we, adv, sel, lnN};
		addrUpper <= a[ADDR_W-1:2];
		burstAddrBitOne <= a[1];
		burstAddrBitZero <= a[0];
		drv <= d;
		drvEn <= den;
	endtask
endmodule

`default_nettype wire

// File: verif/tb_psic_input_control.sv
// self-checking bench of the burst memory input control
`timescale 1ns/1ps
`default_nettype none

module tb_psic_input_control;
	import psic_pkg::*;

	localparam logic [2:0]        SEL_OK  = 3'h2;
	localparam logic [2:0]        SEL_OFF = 3'h6;
	localparam logic [ADDR_W-1:0] A       = 18'h2_A5C4;
	localparam logic [ADDR_W-1:0] BASE    = 18'h1_3370;

	logic                clk;
	logic                rst_b;
	logic                strapSel;
	int                  bad_count;
	int                  n_checks;
	psic_ctrl_t          ctrl;
	logic [UPPER_W-1:0]  addrUpper;
	logic                bitOne;
	logic                bitZero;
	logic                oeN;
	logic                strap;
	logic [DATA_W-1:0]   dataIn;
	logic [DATA_W-1:0]   dataOut;
	logic [DATA_W-1:0]   dataOe;
	logic                accessValid;
	logic                accessWrite;
	logic [ADDR_W-1:0]   accessAddr;
	logic [LANES-1:0]    accessLanes;
	logic [DATA_W-1:0]   exp;
	logic [1:0]          low;
	logic [2:0]          badSel [3] = '{3'h6, 3'h0, 3'h3};

	psic_ctrl_model pm (.clk(clk), .strapSel(strapSel), .ctrl(ctrl), .addrUpper(addrUpper),
		.burstAddrBitOne(bitOne), .burstAddrBitZero(bitZero), .outputEnableN(oeN),
		.burstOrderStrap(strap), .dataOut(dataOut), .dataOe(dataOe), .dataIn(dataIn));

	psic_input_control uut (.clk(clk), .rst_b(rst_b), .ctrl(ctrl), .addrUpper(addrUpper),
		.burstAddrBitOne(bitOne), .burstAddrBitZero(bitZero), .outputEnableN(oeN),
		.burstOrderStrap(strap), .dataIn(dataIn), .dataOut(dataOut), .dataOe(dataOe),
		.accessValid(accessValid), .accessWrite(accessWrite), .accessAddr(accessAddr),
		.accessLanes(accessLanes));

	// ****************************************************************
	// helpers
	// ****************************************************************
	task automatic chk(input string what, input logic [DATA_W-1:0] e, input logic [DATA_W-1:0] g);
		n_checks++;
		if (g !== e) begin
			bad_count++;
			$display("Error %s expected %h seen %h", what, e, g);
		end
	endtask

	task automatic idle();
		pm.issue(1'h0, 1'h1, 1'h0, SEL_OFF, 4'hF, A, 36'h0_0000_0000, 1'h0);
	endtask

	task automatic wr(input logic [3:0] lnN, input logic [DATA_W-1:0] d);
		pm.issue(1'h0, 1'h0, 1'h0, SEL_OK, lnN, A, 36'h0_0000_0000, 1'h0);
		pm.issue(1'h0, 1'h1, 1'h0, SEL_OFF, 4'hF, A, d, 1'h1);
		#1;
		chk("write lanes", DATA_W'(4'hF ^ lnN), DATA_W'(accessLanes));
		chk("write valid", 36'h0_0000_0001, DATA_W'(accessValid));
	endtask

	// lane selects held low on a read must not write
	task automatic rd(input logic [DATA_W-1:0] e);
		pm.issue(1'h0, 1'h1, 1'h0, SEL_OK, 4'h0, A, ~e, 1'h0);
		idle();
		idle();
		#1;
		chk("read data", e, dataOut);
		chk("read enable", 36'hF_FFFF_FFFF, dataOe);
	endtask

	task automatic results();
		if (bad_count == 0 && n_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	// ****************************************************************
	// clock, reset, watchdog
	// ****************************************************************
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	initial begin
		repeat (2000) @(posedge clk);
		bad_count++;
		results();
	end

	// ****************************************************************
	// tests
	// ****************************************************************
	initial begin
		rst_b = 1'h0;
		strapSel = 1'h1;
		bad_count = 0;
		n_checks = 0;
		for (int s = 1; s >= 0; s--) begin
			@(posedge clk);
			rst_b <= 1'h0;
			strapSel <= s[0];
			repeat (4) @(posedge clk);
			rst_b <= 1'h1;
			idle();
			pm.issue(1'h0, 1'h0, 1'h0, SEL_OK, 4'h0, BASE | 18'h1, 36'h0_0000_0000, 1'h0);
			for (int i = 0; i < 5; i++) begin
				pm.issue(1'h0, 1'h1, 1'h1, SEL_OK, 4'h0, 18'h3_FFFF, 36'h0_0000_0000, 1'h0);
				#1;
				low = (s == 1) ? (2'h1 ^ i[1:0]) : (2'h1 + i[1:0]);
				chk("burst addr", DATA_W'({BASE[17:2], low}), DATA_W'(accessAddr));
			end
			idle();
		end
		exp = 36'h1_2345_6789;
		wr(4'h0, exp);
		rd(exp);
		for (int n = 0; n < LANES; n++) begin
			wr(~(4'h1 << n), 36'hE_DCBA_9876);
			exp[9*n +: 9] = 9'(36'hE_DCBA_9876 >> (9*n));
			rd(exp);
		end
		pm.issue(1'h0, 1'h1, 1'h0, SEL_OK, 4'h0, A, 36'h0_0000_0000, 1'h0);
		repeat (3) begin
			pm.issue(1'h1, 1'h0, 1'h0, SEL_OK, 4'h0, BASE, ~exp, 1'h1);
			#1;
			chk("held addr", DATA_W'(A), DATA_W'(accessAddr));
			chk("held type", 36'h0_0000_0000, DATA_W'(accessWrite));
		end
		idle();
		idle();
		#1;
		chk("stretched read", exp, dataOut);
		rd(exp);
		for (int k = 0; k < 3; k++) begin
			pm.issue(1'h0, 1'h0, 1'h0, badSel[k], 4'h0, A, 36'h0_0000_0000, 1'h0);
			pm.issue(1'h0, 1'h1, 1'h0, badSel[k], 4'h0, A, ~exp, 1'h1);
			#1;
			chk("deselect valid", 36'h0_0000_0000, DATA_W'(accessValid));
			idle();
			idle();
			#1;
			chk("deselect enable", 36'h0_0000_0000, dataOe);
			rd(exp);
		end
		pm.outputEnableN <= 1'h1;
		pm.issue(1'h0, 1'h1, 1'h0, SEL_OK, 4'h0, A, 36'h0_0000_0000, 1'h0);
		idle();
		idle();
		#1;
		chk("masked enable", 36'h0_0000_0000, dataOe);
		results();
	end
endmodule

`default_nettype wire
